// [eil_defs.vh]
// Constants for the external interrupt latch block.
// Assumes inclusion by bare name from design and bench files.
`ifndef EIL_DEFS_VH
`define EIL_DEFS_VH

`define EIL_ADDR_W         16
`define EIL_STATUS_CTRL    16'h001A
`define EIL_BIT_SENSE      0
`define EIL_BIT_MASK       1
`define EIL_BIT_ACK        2
`define EIL_BIT_PENDING    3
`define EIL_RST_SENSE      1'b0
`define EIL_RST_MASK       1'b0
`define EIL_RST_LATCH      1'b0
`define EIL_VECTOR_HI      16'hFFFA
`define EIL_VECTOR_LO      16'hFFFB

`endif

// [eil_external_irq_latch.v]
// External interrupt latch with edge or edge-and-level sensitivity.
// Assumes a single 50 MHz bus clock, async active-low reset, an 8-bit register port,
// and a CPU that pulses vectorFetchAck when it fetches this block's vector.
//
// Notes on behaviour
// - A low on the interrupt pin can set the latch, making a pending request.
// - Fetching this vector produces an acknowledge that clears the latch.
// - Writing one to the acknowledge bit clears the latch; zero does nothing.
// - Acknowledge bit is write-only, reads zero, cleared by reset.
// - Reset clears latch and sense select, even with the pin held low.
// - Sense select zero: only falling edges set; an acknowledge clears at once unless a falling edge sets it in the same cycle.
// - Sense select one: clear needs acknowledge and pin high, in either order.
// - In edge-and-level mode the request stays pending while the pin is low.
// - Bit 0 sense select: one gives edges plus low level; reset clears it.
// - Mask bit one blocks the request from priority logic; reset clears it.
// - Pending flag reads one while the latch is set, zero otherwise.
// - Pending flag ignores the mask so software can poll.
// - A falling edge after a software acknowledge sets the latch again.
// - Unmasked latched request makes the CPU load its vector from FFFA/FFFB.
// - In break with clear enable zero, software acknowledge leaves the latch alone.
// - In break with clear enable one, acknowledge clears and it stays cleared.
// - Register: bit3 pending, bit2 ack, bit1 mask, bit0 sense; bits 7-4 zero.
// - The CPU global interrupt mask also blocks the request.
//
// Decided for this implementation: the strobed register port.

`include "eil_defs.vh"
`default_nettype none

module eil_external_irq_latch (
  // Clock and reset
  input  wire                    clk,
  input  wire                    rst_n,
  // Register port
  input  wire [`EIL_ADDR_W-1:0]  regAddr,
  input  wire [7:0]              regWrData,
  input  wire                    regWrStrobe,
  input  wire                    regRdStrobe,
  output reg  [7:0]              regRdData,
  // Interrupt pin, active low
  input  wire                    extIntPin_n,
  // CPU side
  input  wire                    vectorFetchAck,
  input  wire                    cpuGlobalMask,
  output reg                     extIntRequest,
  output reg  [15:0]             extIntVectorAddr,
  // Break controller
  input  wire                    breakState,
  input  wire                    breakClearEnable
);

  // Reset release
  reg rstSync1_reg;
  reg rstSync2_reg;
  wire rstInt_n = rstSync2_reg;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync1_reg <= 1'b0;
      rstSync2_reg <= 1'b0;
    end else begin
      rstSync1_reg <= 1'b1;
      rstSync2_reg <= rstSync1_reg;
    end
  end

  // Pin synchroniser: three stages, a change counts when stages two and three agree
  reg pinS1_reg;
  reg pinS2_reg;
  reg pinS3_reg;
  reg pinLevel_reg;
  reg pinLevel_next;

  always @(posedge clk or negedge rstInt_n) begin
    if (!rstInt_n) begin
      pinS1_reg    <= 1'b1;
      pinS2_reg    <= 1'b1;
      pinS3_reg    <= 1'b1;
      pinLevel_reg <= 1'b1;
    end else begin
      pinS1_reg    <= extIntPin_n;
      pinS2_reg    <= pinS1_reg;
      pinS3_reg    <= pinS2_reg;
      pinLevel_reg <= pinLevel_next;
    end
  end

  always @* begin
    pinLevel_next = pinLevel_reg;
    if (pinS2_reg == pinS3_reg) begin
      pinLevel_next = pinS3_reg;
    end
  end

  // High sample followed by low sample on consecutive cycles
  wire fallingEdge = pinLevel_reg & ~pinLevel_next;
  wire pinLow      = ~pinLevel_next;

  // Register decode
  wire ctrlHit  = (regAddr == `EIL_STATUS_CTRL);
  wire ctrlWr   = regWrStrobe & ctrlHit;
  wire ackWrite = ctrlWr & regWrData[`EIL_BIT_ACK];
  // Break protection keeps a software acknowledge from clearing the latch unless clearing is enabled
  wire swAck    = ackWrite & (~breakState | breakClearEnable);
  wire anyAck   = swAck | vectorFetchAck;

  reg senseSelect_reg;
  reg intMask_reg;
  reg latch_reg;
  reg latch_next;
  // Level mode remembers an acknowledge seen while the pin is still low
  reg ackSeen_reg;
  reg ackSeen_next;

  always @* begin
    latch_next   = latch_reg;
    ackSeen_next = ackSeen_reg;
    if (!senseSelect_reg) begin
      ackSeen_next = 1'b0;
      if (anyAck) begin
        latch_next = 1'b0;
      end
      // Set wins over a simultaneous acknowledge
      if (fallingEdge) begin
        latch_next = 1'b1;
      end
    end else begin
      if (latch_reg && anyAck) begin
        ackSeen_next = 1'b1;
      end
      if (latch_reg && (ackSeen_reg || anyAck) && !pinLow) begin
        latch_next   = 1'b0;
        ackSeen_next = 1'b0;
      end
      if (fallingEdge) begin
        latch_next   = 1'b1;
        ackSeen_next = 1'b0;
      end
      // A low pin keeps the request pending
      if (pinLow && !(ackSeen_reg || anyAck)) begin
        latch_next = 1'b1;
      end
      if (pinLow && latch_reg) begin
        latch_next = 1'b1;
      end
    end
  end

  always @(posedge clk or negedge rstInt_n) begin
    if (!rstInt_n) begin
      senseSelect_reg <= `EIL_RST_SENSE;
      intMask_reg     <= `EIL_RST_MASK;
      latch_reg       <= `EIL_RST_LATCH;
      ackSeen_reg     <= 1'b0;
    end else begin
      latch_reg   <= latch_next;
      ackSeen_reg <= ackSeen_next;
      if (ctrlWr) begin
        senseSelect_reg <= regWrData[`EIL_BIT_SENSE];
        intMask_reg     <= regWrData[`EIL_BIT_MASK];
      end
    end
  end

  // Read path and CPU request, all registered
  always @(posedge clk or negedge rstInt_n) begin
    if (!rstInt_n) begin
      regRdData        <= 8'h00;
      extIntRequest    <= 1'b0;
      extIntVectorAddr <= 16'h0000;
    end else begin
      regRdData <= 8'h00;
      if (regRdStrobe && ctrlHit) begin
        // Acknowledge and upper bits always read zero
        regRdData <= {4'h0, latch_reg, 1'b0, intMask_reg, senseSelect_reg};
      end
      extIntRequest    <= latch_next & ~intMask_reg & ~cpuGlobalMask;
      extIntVectorAddr <= `EIL_VECTOR_HI;
    end
  end

endmodule // eil_external_irq_latch

`default_nettype wire

// [eil_irq_monitor.sv]
// Checker bound to the external interrupt latch top.
// Assumes one clock domain and active-low reset.
`include "eil_defs.vh"
`default_nettype none
module eil_irq_monitor (
  input wire logic        clk, rst_n, regWrStrobe, regRdStrobe, extIntPin_n, vectorFetchAck,
  input wire logic        cpuGlobalMask, extIntRequest, breakState, breakClearEnable,
  input wire logic [15:0] regAddr, extIntVectorAddr,
  input wire logic [7:0]  regWrData, regRdData
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic hit = regAddr == `EIL_STATUS_CTRL;
  wire logic swAck = regWrStrobe && hit && regWrData[2];
  // Pin high through the synchroniser, so no edge can race the clear
  sequence quietPin; extIntPin_n [*4]; endsequence
  a_rd_idle: assert property (!$past(regRdStrobe) |-> !regRdData) else $error("stray rd");
  a_fixed_zero: assert property (!regRdData[7:4] && !regRdData[2]) else $error("bad bits");
  a_rd_pending: assert property ($past(regRdStrobe && hit && extIntRequest) |-> regRdData[3])
    else $error("pending lost");
  a_cpu_mask: assert property ($past(cpuGlobalMask) |-> !extIntRequest) else $error("cpu mask");
  a_vector: assert property (extIntRequest |-> extIntVectorAddr == `EIL_VECTOR_HI) else $error("vec");
  a_fetch_clr: assert property (quietPin ##0 vectorFetchAck |=> !extIntRequest) else $error("fetch");
  a_soft_clr: assert property (quietPin ##0 (swAck && (!breakState || breakClearEnable)) |=>
    !extIntRequest) else $error("soft ack");
  a_brk_keep: assert property (extIntRequest && swAck && breakState && !breakClearEnable &&
    !vectorFetchAck && !regWrData[1] && !cpuGlobalMask |=> extIntRequest) else $error("brk");
endmodule // eil_irq_monitor
bind eil_external_irq_latch eil_irq_monitor eil_irq_monitor_inst (.*);
`default_nettype wire

// [eil_pin_source.sv]
// Model of the source on the interrupt pin.
// Assumes an idle-high pulled-up line.
`default_nettype none
module eil_pin_source (
  input  wire logic clk,
  output var  logic pinLevel_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pinLevel_n = 1'b1;
  task automatic put(input logic v, input int n);
    @(posedge clk);
    pinLevel_n <= v;
    repeat (n) @(posedge clk);
  endtask
endmodule // eil_pin_source
`default_nettype wire

// [eil_external_irq_latch_tb.sv]
// Self-checking bench for the external interrupt latch.
// Assumes the pin source model drives the interrupt pin.
`include "eil_defs.vh"
`default_nettype none
module eil_external_irq_latch_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, regWrStrobe, regRdStrobe, vectorFetchAck, cpuGlobalMask, breakState;
  logic breakClearEnable, rdPend;
  logic [15:0] regAddr, seed, r;
  logic [7:0] regWrData, expQ[$];
  wire logic [7:0] regRdData;
  wire logic [15:0] extIntVectorAddr;
  wire logic extIntRequest, extIntPin_n;
  int fails, n_compared;
  eil_external_irq_latch eil_external_irq_latch_inst (.*);
  eil_pin_source eil_pin_source_inst (.clk(clk), .pinLevel_n(extIntPin_n));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [15:0] xs();
    seed ^= seed << 7;
    seed ^= seed >> 9;
    seed ^= seed << 8;
    return seed;
  endfunction
  task automatic cmp(input string what, input logic [7:0] e, g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic summarize();
    if (fails == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    {regAddr, regWrData, regWrStrobe, regRdStrobe} <= {a, d, wr, !wr};
    if (!wr) expQ.push_back(d);
    @(posedge clk);
    {regWrStrobe, regRdStrobe} <= 2'h0;
  endtask
  task automatic req(input logic e);
    repeat (6) @(posedge clk);
    cmp("request", {7'h00, e}, {7'h00, extIntRequest});
  endtask
  task automatic edge1();
    eil_pin_source_inst.put(1'b0, 2);
    eil_pin_source_inst.put(1'b1, 0);
  endtask
  always @(posedge clk) begin
    if (rdPend) cmp("readback", expQ.pop_front(), regRdData);
    rdPend <= regRdStrobe;
  end
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    summarize();
  end
  initial begin
    {rst_n, regWrStrobe, regRdStrobe, vectorFetchAck, cpuGlobalMask, breakState} = 6'h00;
    {breakClearEnable, rdPend, regAddr, regWrData, seed} = {2'h0, 24'h000000, 16'hFE97};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    bus(1'b0, `EIL_STATUS_CTRL, 8'h00);
    repeat (4) begin
      r = xs();
      bus(1'b1, r | 16'h8000, r[15:8]);
      bus(1'b0, r | 16'h8000, 8'h00);
    end
    edge1();
    req(1'b1);
    bus(1'b0, `EIL_STATUS_CTRL, 8'h08);
    bus(1'b1, `EIL_STATUS_CTRL, 8'h04);
    bus(1'b0, `EIL_STATUS_CTRL, 8'h00);
    edge1();
    req(1'b1);
    @(posedge clk) vectorFetchAck <= 1'b1;
    @(posedge clk) vectorFetchAck <= 1'b0;
    req(1'b0);
    bus(1'b1, `EIL_STATUS_CTRL, 8'h02);
    edge1();
    req(1'b0);
    bus(1'b0, `EIL_STATUS_CTRL, 8'h0A);
    bus(1'b1, `EIL_STATUS_CTRL, 8'h00);
    req(1'b1);
    cpuGlobalMask <= 1'b1;
    req(1'b0);
    {cpuGlobalMask, breakState} <= 2'h1;
    bus(1'b1, `EIL_STATUS_CTRL, 8'h04);
    req(1'b1);
    breakClearEnable <= 1'b1;
    bus(1'b1, `EIL_STATUS_CTRL, 8'h04);
    breakState <= 1'b0;
    req(1'b0);
    bus(1'b1, `EIL_STATUS_CTRL, 8'h01);
    eil_pin_source_inst.put(1'b0, 2);
    req(1'b1);
    // Routine acks and masks while the pin is still low
    bus(1'b1, `EIL_STATUS_CTRL, 8'h07);
    bus(1'b0, `EIL_STATUS_CTRL, 8'h0B);
    eil_pin_source_inst.put(1'b1, 6);
    bus(1'b0, `EIL_STATUS_CTRL, 8'h03);
    summarize();
  end
endmodule // eil_external_irq_latch_tb
`default_nettype wire
